// [hw/pvr_band_search.sv]
// Successive-approximation search for the nearest oscillator band
`timescale 1ns/10ps
module pvr_band_search #(
  parameter int BAND_W = pvr_pkg::BAND_W,
  parameter int SETTLE = pvr_pkg::SETTLE_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 start,
  input  wire logic [18:0]          errMag,
  input  wire logic                 errNeg,
  output logic      [BAND_W-1:0]    trialBand,
  output pvr_pkg::pvr_cal_stat_t    stat
);
  localparam int CW = $clog2(SETTLE + 1);

  if (BAND_W != pvr_pkg::BAND_W || SETTLE < 1) begin : g_chk
    $error("pvr_band_search: unsupported parameters");
  end

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_SETTLE = 2'b01,
    S_DECIDE = 2'b11
  } pvr_srch_t;

  pvr_srch_t         state_q;
  logic [BAND_W-1:0] mask_q;
  logic [CW-1:0]     cnt_q;
  logic [BAND_W-1:0] keep;

  // Larger code is a lower band: a low reading drops the trial bit
  assign keep = errNeg ? (trialBand & ~mask_q) : trialBand;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= S_IDLE;
      mask_q    <= '0;
      cnt_q     <= '0;
      trialBand <= '0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q   <= S_SETTLE;
            mask_q    <= {1'b1, {(BAND_W-1){1'b0}}};
            trialBand <= {1'b1, {(BAND_W-1){1'b0}}};
            cnt_q     <= CW'(SETTLE - 1);
          end
        end
        S_SETTLE: begin
          if (cnt_q == '0) begin
            state_q <= S_DECIDE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_DECIDE: begin
          mask_q    <= mask_q >> 1;
          trialBand <= keep | (mask_q >> 1);
          cnt_q     <= CW'(SETTLE - 1);
          state_q   <= mask_q[0] ? S_IDLE : S_SETTLE;
        end
      endcase
    end
  end

  // ****************************************
  // Status
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stat <= '{busy: 1'b0, band: pvr_pkg::RST_BAND,
                errNeg: pvr_pkg::RST_ERR_NEG,
                errMag: pvr_pkg::RST_ERR_MAG};
    end else begin
      if (state_q == S_IDLE && start) begin
        stat.busy <= 1'b1;
      end
      if (state_q == S_DECIDE) begin
        stat.errMag <= errMag;
        stat.errNeg <= errNeg;
        if (mask_q[0]) begin
          stat.busy <= 1'b0;
          stat.band <= keep;
        end
      end
    end
  end

endmodule : pvr_band_search

// [hw/pvr_pkg.sv]
// Shared constants and carriers for the synthesizer status/indirect block
package pvr_pkg;

  // ****************************************
  // Widths and offsets
  // ****************************************
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 24;
  localparam int          OSC_W          = 9;
  localparam int          BAND_W         = 8;
  localparam int          MAG_W          = 19;
  localparam int          TEST_W         = 17;
  localparam logic [7:0]  OFS_INDIRECT   = 8'h05;
  localparam logic [7:0]  OFS_BAND_STAT  = 8'h10;
  localparam logic [7:0]  OFS_ERR_STAT   = 8'h11;
  localparam logic [7:0]  OFS_LOCK_STAT  = 8'h12;
  localparam logic [7:0]  OFS_SELF_TEST  = 8'h13;
  localparam logic [3:0]  OSC_TUNING     = 4'h0;
  localparam logic [3:0]  OSC_ENABLES    = 4'h1;
  localparam logic [3:0]  OSC_DIVIDER    = 4'h2;
  localparam logic [3:0]  OSC_CONFIG     = 4'h3;
  localparam logic [2:0]  ID_OSC         = 3'h0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          ID_LSB         = 0;
  localparam int          OADDR_LSB      = 3;
  localparam int          ODATA_LSB      = 7;
  localparam int          TUNE_CAL_BIT   = 0;
  localparam int          SUBBAND_LSB    = 1;
  localparam int          EN_MASTER      = 0;
  localparam int          EN_OSC         = 1;
  localparam int          EN_PLLBUF      = 2;
  localparam int          EN_IO          = 3;
  localparam int          EN_OUTSTAGE    = 5;
  localparam int          DIV_LSB        = 0;
  localparam int          MODE_LSB       = 0;
  localparam int          BUSY_BIT       = 8;
  localparam int          SIGN_BIT       = 19;
  localparam int          GPO_BIT        = 0;
  localparam int          LOCK_BIT       = 1;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [8:0]  RST_TUNING     = 9'h020;
  localparam logic [8:0]  RST_ENABLES    = 9'h1BF;
  localparam logic [8:0]  RST_DIVIDER    = 9'h001;
  localparam logic [8:0]  RST_CONFIG     = 9'h091;
  localparam logic [7:0]  RST_BAND       = 8'h20;
  localparam logic [18:0] RST_ERR_MAG    = 19'h0_7FFF;
  localparam logic        RST_ERR_NEG    = 1'b0;
  localparam logic [16:0] SELF_TEST_VAL  = 17'h0_0000;
  localparam logic [5:0]  DIV_MAX        = 6'h3E;
  localparam logic [1:0]  MODE_LOW_NOISE = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_NS         = 10;
  localparam int          SETTLE_NS      = 1000;
  localparam int          SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        calVolt;
    logic [7:0]  subband;
    logic        oscEn;
    logic        pllBufEn;
    logic        outDivEn;
    logic        outStageEn;
    logic        outMute;
    logic [5:0]  divRatio;
    logic        lowNoise;
  } pvr_osc_ctrl_t;

  typedef struct packed {
    logic        busy;
    logic [7:0]  band;
    logic        errNeg;
    logic [18:0] errMag;
  } pvr_cal_stat_t;

endpackage : pvr_pkg

// [hw/pvr_pll_status_regs.sv]
// Status registers and indirect oscillator register bank
// Functional notes
// - Band status shows calibrated band choice
// - Manual band change leaves status unchanged
// - Code zero is highest frequency band
// - Busy bit high during band search
// - Error status: magnitude low, sign above
// - Status reports output level and lock
// - Oscillator registers reached through indirect register
// - Tuning bit zero selects calibration voltage
// - Tuning bits select oscillator sub-band
// - Master enable clear turns everything off
// - Enables for oscillators and loop buffer
// - IO enable drives output stage, divider
// - Output stage enable clear disables stage
// - Divider: zero mutes, one passes, even divides
// - Odd codes round down, above 62 clamp
// - Mode field picks current or noise priority
// - Code 11 low noise, 01 low current
`timescale 1ns/10ps
module pvr_pll_status_regs #(
  parameter int SETTLE = pvr_pkg::SETTLE_CYC
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  input  wire logic                          regWrStb,
  input  wire logic [pvr_pkg::ADDR_W-1:0]    regWrAddr,
  input  wire logic [pvr_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                          regRdStb,
  input  wire logic [pvr_pkg::ADDR_W-1:0]    regRdAddr,
  output logic      [pvr_pkg::DATA_W-1:0]    regRdData,
  input  wire logic                          calStart,
  input  wire logic [pvr_pkg::MAG_W-1:0]     errMag,
  input  wire logic                          errNeg,
  input  wire logic                          gpoPin,
  input  wire logic                          lockPin,
  output pvr_pkg::pvr_osc_ctrl_t             oscCtrl
);

  if (SETTLE < 1) begin : g_chk
    $error("pvr_pll_status_regs: SETTLE must be at least 1");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [pvr_pkg::OSC_W-1:0]  tuning_q;
  logic [pvr_pkg::OSC_W-1:0]  enables_q;
  logic [pvr_pkg::OSC_W-1:0]  divider_q;
  logic [pvr_pkg::OSC_W-1:0]  config_q;
  logic                       useCal_q;
  logic [1:0]                 gpoSync_q;
  logic [1:0]                 lockSync_q;
  logic [pvr_pkg::BAND_W-1:0] trialBand;
  pvr_pkg::pvr_cal_stat_t     stat;
  logic                       indWr;
  logic [3:0]                 oAddr;
  logic [pvr_pkg::OSC_W-1:0]  oData;
  logic [5:0]                 divCode;
  logic [5:0]                 ratio;
  logic                       master;

  // ****************************************
  // Band search engine
  // ****************************************
  pvr_band_search #(
    .BAND_W (pvr_pkg::BAND_W),
    .SETTLE (SETTLE)
  ) u_search (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .start     (calStart),
    .errMag    (errMag),
    .errNeg    (errNeg),
    .trialBand (trialBand),
    .stat      (stat)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gpoSync_q  <= 2'h0;
      lockSync_q <= 2'h0;
    end else begin
      gpoSync_q  <= {gpoSync_q[0], gpoPin};
      lockSync_q <= {lockSync_q[0], lockPin};
    end
  end

  // ****************************************
  // Indirect write decode
  // ****************************************
  // Other subsystem identifiers belong to nobody here and are dropped
  assign oAddr = regWrData[pvr_pkg::OADDR_LSB +: 4];
  assign oData = regWrData[pvr_pkg::ODATA_LSB +: pvr_pkg::OSC_W];
  assign indWr = regWrStb && regWrAddr == pvr_pkg::OFS_INDIRECT &&
                 regWrData[pvr_pkg::ID_LSB +: 3] == pvr_pkg::ID_OSC;

  // Whole word replaces the target; no read-modify-write is possible
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tuning_q  <= pvr_pkg::RST_TUNING;
      enables_q <= pvr_pkg::RST_ENABLES;
      divider_q <= pvr_pkg::RST_DIVIDER;
      config_q  <= pvr_pkg::RST_CONFIG;
    end else if (indWr) begin
      unique case (oAddr)
        pvr_pkg::OSC_TUNING:  tuning_q  <= oData;
        pvr_pkg::OSC_ENABLES: enables_q <= oData;
        pvr_pkg::OSC_DIVIDER: divider_q <= oData;
        pvr_pkg::OSC_CONFIG:  config_q  <= oData;
        default: ;
      endcase
    end
  end

  // Last band source: search result until a manual tuning write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      useCal_q <= 1'b0;
    end else if (stat.busy) begin
      useCal_q <= 1'b1;
    end else if (indWr && oAddr == pvr_pkg::OSC_TUNING) begin
      useCal_q <= 1'b0;
    end
  end

  // ****************************************
  // Oscillator control outputs
  // ****************************************
  assign divCode = divider_q[pvr_pkg::DIV_LSB +: 6];
  assign master  = enables_q[pvr_pkg::EN_MASTER];

  always_comb begin
    if (divCode == 6'h00 || divCode == 6'h01) begin
      ratio = divCode;
    end else if (divCode > pvr_pkg::DIV_MAX) begin
      ratio = pvr_pkg::DIV_MAX;
    end else begin
      ratio = {divCode[5:1], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oscCtrl <= '0;
    end else begin
      oscCtrl.calVolt    <= tuning_q[pvr_pkg::TUNE_CAL_BIT];
      oscCtrl.subband    <= stat.busy ? trialBand :
                            useCal_q  ? stat.band :
                            tuning_q[pvr_pkg::SUBBAND_LSB +: 8];
      oscCtrl.oscEn      <= master && enables_q[pvr_pkg::EN_OSC];
      oscCtrl.pllBufEn   <= master &&
                            enables_q[pvr_pkg::EN_PLLBUF];
      oscCtrl.outDivEn   <= master && enables_q[pvr_pkg::EN_IO];
      oscCtrl.outStageEn <= master && enables_q[pvr_pkg::EN_IO] &&
                            enables_q[pvr_pkg::EN_OUTSTAGE];
      oscCtrl.outMute    <= ratio == 6'h00 || !master ||
                            !enables_q[pvr_pkg::EN_IO] ||
                            !enables_q[pvr_pkg::EN_OUTSTAGE];
      oscCtrl.divRatio   <= ratio;
      // Unsupported codes fall back to the low-current setting
      oscCtrl.lowNoise   <= config_q[pvr_pkg::MODE_LSB +: 2] ==
                            pvr_pkg::MODE_LOW_NOISE;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= '0;
    end else if (regRdStb) begin
      regRdData <= '0;
      unique case (regRdAddr)
        pvr_pkg::OFS_BAND_STAT: begin
          regRdData[7:0] <= stat.band;
          regRdData[pvr_pkg::BUSY_BIT] <= stat.busy;
        end
        pvr_pkg::OFS_ERR_STAT: begin
          regRdData[pvr_pkg::MAG_W-1:0] <= stat.errMag;
          regRdData[pvr_pkg::SIGN_BIT]  <= stat.errNeg;
        end
        pvr_pkg::OFS_LOCK_STAT: begin
          regRdData[pvr_pkg::GPO_BIT]  <= gpoSync_q[1];
          regRdData[pvr_pkg::LOCK_BIT] <= lockSync_q[1];
        end
        pvr_pkg::OFS_SELF_TEST: begin
          regRdData[pvr_pkg::TEST_W-1:0] <= pvr_pkg::SELF_TEST_VAL;
        end
        // Indirect and unmapped addresses read zero
        default: ;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_tune_wr;
    indWr && oAddr == pvr_pkg::OSC_TUNING;
  endsequence

  sequence s_rd(logic [7:0] a);
    regRdStb && regRdAddr == a;
  endsequence

  property p_busy_span;
    $rose(stat.busy) |-> stat.busy [*8];
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("busy flag dropped early");

  property p_manual_keep;
    s_tune_wr |=> $stable(stat.band);
  endproperty
  a_manual_keep: assert property (p_manual_keep)
    else $error("band status followed manual write");

  property p_ind_wr;
    s_tune_wr |=> tuning_q == $past(oData);
  endproperty
  a_ind_wr: assert property (p_ind_wr)
    else $error("indirect data not transferred");

  property p_master_off;
    !master |=> !oscCtrl.oscEn && !oscCtrl.pllBufEn &&
                !oscCtrl.outDivEn && !oscCtrl.outStageEn;
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("block on with master enable clear");

  property p_stage_off;
    master && enables_q[pvr_pkg::EN_IO] &&
    !enables_q[pvr_pkg::EN_OUTSTAGE]
      |=> !oscCtrl.outStageEn && oscCtrl.outDivEn;
  endproperty
  a_stage_off: assert property (p_stage_off)
    else $error("output stage enable mishandled");

  property p_io_osc;
    master && enables_q[pvr_pkg::EN_OSC] && !enables_q[pvr_pkg::EN_IO]
      |=> oscCtrl.oscEn && !oscCtrl.outDivEn;
  endproperty
  a_io_osc: assert property (p_io_osc)
    else $error("IO enable touched oscillator enable");

  property p_div_clamp;
    divCode > pvr_pkg::DIV_MAX |=> oscCtrl.divRatio == 6'h3E;
  endproperty
  a_div_clamp: assert property (p_div_clamp)
    else $error("divider not clamped to 62");

  property p_div_odd;
    divCode[0] && divCode > 6'h01 && divCode < 6'h3F
      |=> oscCtrl.divRatio == $past(divCode) - 6'h01;
  endproperty
  a_div_odd: assert property (p_div_odd)
    else $error("odd divider not rounded down");

  property p_div_mute;
    divCode == 6'h00 |=> oscCtrl.outMute;
  endproperty
  a_div_mute: assert property (p_div_mute)
    else $error("divider zero did not mute");

  property p_mode;
    config_q[1:0] != 2'h3 |=> !oscCtrl.lowNoise;
  endproperty
  a_mode: assert property (p_mode)
    else $error("low-noise mode without code 11");

  property p_rd_band;
    s_rd(pvr_pkg::OFS_BAND_STAT)
      |=> regRdData[8:0] == $past({stat.busy, stat.band});
  endproperty
  a_rd_band: assert property (p_rd_band)
    else $error("band status read wrong");

  property p_rd_lock;
    s_rd(pvr_pkg::OFS_LOCK_STAT)
      |=> regRdData[1:0] == $past({lockSync_q[1], gpoSync_q[1]});
  endproperty
  a_rd_lock: assert property (p_rd_lock)
    else $error("lock status read wrong");

  property p_rd_wo;
    s_rd(pvr_pkg::OFS_INDIRECT) |=> regRdData == '0;
  endproperty
  a_rd_wo: assert property (p_rd_wo)
    else $error("indirect register read back data");

endmodule : pvr_pll_status_regs

// [verif/pvr_host_model.sv]
// Parallel-bus host model issuing single-cycle register writes and reads
`timescale 1ns/10ps
module pvr_host_model (
  input  wire logic        mclk,
  output logic             regWrStb,
  output logic [7:0]       regWrAddr,
  output logic [23:0]      regWrData,
  output logic             regRdStb,
  output logic [7:0]       regRdAddr,
  input  wire logic [23:0] regRdData
);
  // ****************************************
  // Bus tasks
  // ****************************************
  initial begin
    regWrStb  = 1'b0;
    regWrAddr = 8'h00;
    regWrData = 24'h00_0000;
    regRdStb  = 1'b0;
    regRdAddr = 8'h00;
  end

  // Idle bus shows inverted data, so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge mclk);
    regWrStb  <= 1'b1;
    regWrAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrStb  <= 1'b0;
    regWrAddr <= ~a;
    regWrData <= ~d;
  endtask : wr

  // Whole nine bits resent; host keeps its own copy
  task automatic wrOsc(input logic [2:0] id, input logic [3:0] ra,
                       input logic [8:0] v);
    wr(8'h05, {8'h00, v, ra, id});
  endtask : wrOsc

  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge mclk);
    regRdStb  <= 1'b1;
    regRdAddr <= a;
    @(posedge mclk);
    regRdStb  <= 1'b0;
    regRdAddr <= ~a;
    #1;
    d = regRdData;
  endtask : rd
endmodule : pvr_host_model

// [verif/tb_pll_status_vco_indirect_regs.sv]
// Testbench for the status and indirect oscillator register block
`timescale 1ns/10ps
module tb_pll_status_vco_indirect_regs;
  // ****************************************
  // Signals
  // ****************************************
  localparam int         SET = 2;
  localparam logic [7:0] TGT = 8'h5A;
  logic                         mclk;
  logic                         rst_b;
  logic                         calStart;
  logic                         errNeg;
  logic                         gpoPin;
  logic                         lockPin;
  logic [pvr_pkg::MAG_W-1:0]    errMag;
  logic                         regWrStb;
  logic                         regRdStb;
  logic [7:0]                   regWrAddr;
  logic [7:0]                   regRdAddr;
  logic [23:0]                  regWrData;
  logic [23:0]                  regRdData;
  pvr_pkg::pvr_osc_ctrl_t       oscCtrl;
  logic [8:0]                   tuneS;
  logic [8:0]                   enS;
  logic [8:0]                   divS;
  logic [8:0]                   cfgS;
  int                           errTotal;
  int                           nCompared;
  int                           cyc;

  pvr_pll_status_regs #(.SETTLE(SET)) i_pvr_pll_status_regs (
    .mclk(mclk), .rst_b(rst_b), .regWrStb(regWrStb),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdStb(regRdStb),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .calStart(calStart),
    .errMag(errMag), .errNeg(errNeg), .gpoPin(gpoPin),
    .lockPin(lockPin), .oscCtrl(oscCtrl));

  pvr_host_model i_pvr_host_model (
    .mclk(mclk), .regWrStb(regWrStb), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .regRdStb(regRdStb), .regRdAddr(regRdAddr),
    .regRdData(regRdData));

  always #5 mclk = ~mclk;

  // Trial above target means oscillator too slow
  always @(posedge mclk) errNeg <= (oscCtrl.subband > TGT);

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errTotal++;
      testDone();
    end
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdChk(input logic [7:0] a, input logic [23:0] exp);
    logic [23:0] d;
    i_pvr_host_model.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask : rdChk

  function automatic pvr_pkg::pvr_osc_ctrl_t expCtrl();
    pvr_pkg::pvr_osc_ctrl_t e;
    logic                   m;
    logic [5:0]             c;
    m = enS[0];
    c = divS[5:0];
    e.calVolt    = tuneS[0];
    e.subband    = tuneS[8:1];
    e.oscEn      = m & enS[1];
    e.pllBufEn   = m & enS[2];
    e.outDivEn   = m & enS[3];
    e.outStageEn = m & enS[3] & enS[5];
    e.divRatio   = (c > 6'h3E) ? 6'h3E :
                   (c == 6'h01) ? c : {c[5:1], 1'b0};
    e.outMute    = (e.divRatio == 6'h00) | ~e.outStageEn;
    e.lowNoise   = (cfgS[1:0] == 2'h3);
    return e;
  endfunction : expCtrl

  task automatic setOsc(input logic [3:0] ra, input logic [8:0] v);
    case (ra)
      4'h0: tuneS = v;
      4'h1: enS = v;
      4'h2: divS = v;
      default: cfgS = v;
    endcase
    i_pvr_host_model.wrOsc(pvr_pkg::ID_OSC, ra, v);
    @(posedge mclk);
    #1;
    chk("oscCtrl", 24'(oscCtrl), 24'(expCtrl()));
  endtask : setOsc

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tReset();
    chk("oscCtrl", 24'(oscCtrl), 24'(expCtrl()));
    rdChk(8'h10, 24'h00_0020);
    rdChk(8'h11, 24'h00_7FFF);
    rdChk(8'h12, 24'h00_0000);
    rdChk(8'h13, 24'h00_0000);
    rdChk(8'h05, 24'h00_0000);
    rdChk(8'h20, 24'h00_0000);
  endtask : tReset

  task automatic tEnables();
    setOsc(4'h1, 9'h1DF);
    setOsc(4'h1, 9'h1F7);
    setOsc(4'h1, 9'h1FE);
    setOsc(4'h1, 9'h1FB);
    setOsc(4'h1, 9'h1FD);
    setOsc(4'h1, 9'h1BF);
  endtask : tEnables

  task automatic tDivider();
    logic [5:0] codes [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05,
                              6'h3C, 6'h3D, 6'h3E, 6'h3F};
    foreach (codes[i]) setOsc(4'h2, {3'h0, codes[i]});
    setOsc(4'h2, 9'h001);
  endtask : tDivider

  task automatic tMode();
    for (int m = 0; m < 5; m++) begin
      setOsc(4'h3, {cfgS[8:2], 2'(m ^ 4)});
    end
  endtask : tMode

  // Wrong id, unused target and other address must not land
  task automatic tRefuse();
    i_pvr_host_model.wrOsc(3'h1, 4'h1, 9'h000);
    i_pvr_host_model.wrOsc(3'h0, 4'h4, 9'h000);
    i_pvr_host_model.wr(8'h06, 24'h00_0008);
    repeat (2) @(posedge mclk);
    #1;
    chk("refused", 24'(oscCtrl), 24'(expCtrl()));
  endtask : tRefuse

  task automatic tSearch();
    logic [23:0] d;
    @(posedge mclk);
    errMag   <= 19'h0_1234;
    calStart <= 1'b1;
    @(posedge mclk);
    calStart <= 1'b0;
    repeat (3) @(posedge mclk);
    calStart <= 1'b1;
    @(posedge mclk);
    calStart <= 1'b0;
    i_pvr_host_model.rd(8'h10, d);
    chk("busy early", 24'(d[8]), 24'h00_0001);
    repeat (14) @(posedge mclk);
    i_pvr_host_model.rd(8'h10, d);
    chk("busy late", 24'(d[8]), 24'h00_0001);
    repeat (4) @(posedge mclk);
    rdChk(8'h10, {16'h0000, TGT});
    rdChk(8'h11, 24'h08_1234);
    // Sub-band output holds the search result until a manual write
    chk("subband", 24'(oscCtrl.subband), 24'(TGT));
    setOsc(4'h0, 9'h067);
    rdChk(8'h10, {16'h0000, TGT});
  endtask : tSearch

  task automatic tLock();
    @(posedge mclk);
    gpoPin  <= 1'b1;
    lockPin <= 1'b0;
    repeat (4) @(posedge mclk);
    rdChk(8'h12, 24'h00_0001);
    @(posedge mclk);
    gpoPin  <= 1'b0;
    lockPin <= 1'b1;
    repeat (4) @(posedge mclk);
    rdChk(8'h12, 24'h00_0002);
  endtask : tLock

  task automatic testDone();
    if (errTotal == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : testDone

  initial begin
    mclk      = 1'b0;
    rst_b     = 1'b0;
    calStart  = 1'b0;
    errMag    = 19'h0_0000;
    errNeg    = 1'b0;
    gpoPin    = 1'b0;
    lockPin   = 1'b0;
    tuneS     = pvr_pkg::RST_TUNING;
    enS       = pvr_pkg::RST_ENABLES;
    divS      = pvr_pkg::RST_DIVIDER;
    cfgS      = pvr_pkg::RST_CONFIG;
    errTotal  = 0;
    nCompared = 0;
    cyc       = 0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    tReset();
    tEnables();
    tDivider();
    tMode();
    tRefuse();
    tSearch();
    tLock();
    testDone();
  end
endmodule : tb_pll_status_vco_indirect_regs
